// ===== design/prereg_defs.svh
`ifndef PREREG_DEFS_SVH
`define PREREG_DEFS_SVH

// Register byte addresses
`define A_STATUS 8'h00
`define A_MASK 8'h04
`define A_CTRL 8'h08
`define A_STATE 8'h0C

// Status and mask bit positions
`define B_OVC 0
`define B_SCG 1
`define B_SINK 2

// Control bit positions
`define C_SCOFF 0
`define C_SKOFF 1
`define C_UVR_LO 2
`define C_UVR_HI 4
`define C_THR_LO 8
`define C_THR_HI 11

// Reset values
`define CTRL_RST 32'h0000_0F04
`define MASK_RST 3'h7

// Sink-current persistence time
`define CLK_PERIOD_NS 5
`define SINK_TIME_NS 20000
`define SINK_CYC (`SINK_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== design/prereg_overcurrent_fault_response.sv
`timescale 1ns/1ps
`include "prereg_defs.svh"

module prereg_overcurrent_fault_response #(
  parameter int RESET_TIMEOUT_CYC = 200000, // RESET state timeout
  parameter int TO_W = 18 // Timeout counter width
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic hs_ovc_pin, // HS current above overload
  input wire logic ls_ovc_pin, // LS current above overload
  input wire logic hs_scg_pin, // HS current above short limit
  input wire logic ls_scg_pin, // LS current above short limit
  input wire logic ls_sink_pin, // LS sink current above limit
  input wire logic prereg_uv_ok_pin, // Preregulator above UV
  input wire logic outputs_below_uv_pin, // All outputs below UV
  input wire logic prereg_crit_pin, // Other critical condition
  input wire logic wake_pin, // Wake-up from OFF
  output logic wide_input_preregulator_en, // Preregulator enable
  output logic hs_force_off, // Force HS switch off
  output logic ls_force_on, // Force LS switch on
  output logic low_voltage_step_down_en, // Low-voltage buck enable
  output logic boost_en, // Boost enable
  output logic discharge_en, // Resistive discharge enable
  output logic interrupt_enable_drive_pin_n, // Pin, low asserts
  output logic irq, // Level interrupt
  output logic power_off // Device in OFF state
);

  if (RESET_TIMEOUT_CYC < 2 || RESET_TIMEOUT_CYC >= (1 << TO_W)) begin : g_chk
    $error("RESET_TIMEOUT_CYC does not fit TO_W");
  end

  localparam logic [TO_W-1:0] TO_LAST = TO_W'(RESET_TIMEOUT_CYC - 1); // Final count

  // Pin synchronisers
  logic [8:0] pin_vec; // Raw pins
  logic [8:0] sync1_reg; // First stage
  logic [8:0] sync2_reg; // Second stage, safe to use
  assign pin_vec = {wake_pin, prereg_crit_pin, outputs_below_uv_pin, prereg_uv_ok_pin,
                    ls_sink_pin, ls_scg_pin, hs_scg_pin, ls_ovc_pin, hs_ovc_pin};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_vec;
      sync2_reg <= sync1_reg;
    end
  end

  // Synchronised events
  logic ovc_now; // Either switch above overload
  logic scg_now; // Either switch above short limit
  logic uv_ok; // Preregulator above UV
  logic below_uv; // All outputs discharged
  logic crit; // Critical condition
  logic wake; // Wake request
  logic sink_qual; // Sink event outside the start-up blank
  logic sink_exp; // Sink event persisted
  assign ovc_now = sync2_reg[0] | sync2_reg[1];
  assign scg_now = sync2_reg[2] | sync2_reg[3];
  assign uv_ok = sync2_reg[5];
  assign below_uv = sync2_reg[6];
  assign crit = sync2_reg[7];
  assign wake = sync2_reg[8];

  // Registers of the sequencer
  prereg_pkg::seq_state_e state_reg, state_next; // Sequencer state
  logic pre_en_reg, pre_en_next; // Preregulator enable
  logic hs_off_reg, hs_off_next; // HS forced off
  logic ls_on_reg, ls_on_next; // LS forced on
  logic lv_en_reg, lv_en_next; // Low-voltage buck enable
  logic bst_en_reg, bst_en_next; // Boost enable
  logic dis_reg, dis_next; // Discharge enable
  logic [1:0] latch_reg, latch_next; // Always-on fault latch {sink, short}
  logic [3:0] err_cnt_reg, err_cnt_next; // Device error counter
  logic [TO_W-1:0] to_cnt_reg, to_cnt_next; // RESET timeout counter
  logic [2:0] stat_set; // Hardware set of status flags
  logic [1:0] rpt_set; // Latch report at wake
  logic pin_set; // SAFE or threshold OFF entry pulls the pin low
  logic off_reg, off_next; // OFF state flag for the output

  // Registers seen by software
  logic [2:0] status_reg, status_next; // Sticky status, write 1 clears
  logic [2:0] mask_reg, mask_next; // Interrupt mask
  logic [31:0] ctrl_reg, ctrl_next; // Control
  logic pin_n_reg, pin_n_next; // Interrupt pin level, low asserts
  logic irq_reg, irq_next; // Interrupt output
  logic [31:0] rdata_reg, rdata_next; // Read data
  logic rdy_reg, rdy_next; // Ready
  logic err_reg, err_next; // Slave error
  logic [3:0] thr; // Power-down threshold
  assign thr = ctrl_reg[`C_THR_HI:`C_THR_LO];

  // Sink events are blanked while the output is still rising
  assign sink_qual = sync2_reg[4] & ~(pre_en_reg & ~uv_ok);

  // Sink persistence timer
  sink_timer #(
    .CNT_W(12),
    .LIMIT(`SINK_CYC)
  ) u_sink_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .active(sink_qual & pre_en_reg),
    .expired(sink_exp)
  );

  // Sequencer next state
  always_comb begin
    logic fault; // Leave on a fault
    logic fault_off; // Configured to go OFF
    logic [1:0] fault_lat; // Latch bit of that fault
    logic [3:0] cnt_inc; // Counter after increment
    fault = 1'b0;
    fault_off = 1'b0;
    fault_lat = 2'h0;
    cnt_inc = err_cnt_reg + 4'h1;
    state_next = state_reg;
    pre_en_next = pre_en_reg;
    hs_off_next = 1'b0;
    ls_on_next = 1'b0;
    lv_en_next = lv_en_reg;
    bst_en_next = bst_en_reg;
    dis_next = dis_reg;
    latch_next = latch_reg;
    err_cnt_next = err_cnt_reg;
    to_cnt_next = to_cnt_reg;
    stat_set = {sink_qual, 1'b0, ovc_now};
    rpt_set = 2'h0;
    pin_set = 1'b0;
    case (state_reg)
      prereg_pkg::ST_ACTIVE, prereg_pkg::ST_RESET: begin
        if (state_reg == prereg_pkg::ST_RESET) begin
          // Bring up the chain: preregulator, buck, then boost
          pre_en_next = ~crit;
          if (pre_en_reg && uv_ok) begin
            lv_en_next = 1'b1;
          end
          if (lv_en_reg) begin
            bst_en_next = 1'b1;
          end
          to_cnt_next = to_cnt_reg + 1'b1;
          if (bst_en_reg && pre_en_reg && uv_ok) begin
            state_next = prereg_pkg::ST_ACTIVE;
          end else if (to_cnt_reg == TO_LAST) begin
            // Never recovered: power down
            state_next = prereg_pkg::ST_OFF;
            pre_en_next = 1'b0;
            lv_en_next = 1'b0;
            bst_en_next = 1'b0;
            dis_next = 1'b1;
          end
        end
        if (scg_now) begin
          // HS off at once, LS on to drain the inductor
          state_next = prereg_pkg::ST_SC_HOLD;
          hs_off_next = 1'b1;
          ls_on_next = 1'b1;
        end else if (sink_exp) begin
          fault = 1'b1;
          fault_off = ctrl_reg[`C_SKOFF];
          fault_lat = 2'h2;
        end
      end
      prereg_pkg::ST_SC_HOLD: begin
        hs_off_next = 1'b1;
        ls_on_next = 1'b1;
        if (!ovc_now) begin
          // Current is back under overload: disable and report
          stat_set[`B_SCG] = 1'b1;
          fault = 1'b1;
          fault_off = ctrl_reg[`C_SCOFF];
          fault_lat = 2'h1;
        end
      end
      prereg_pkg::ST_SAFE: begin
        // Wait for discharge with a reset-class UV enabled
        if (below_uv && |ctrl_reg[`C_UVR_HI:`C_UVR_LO]) begin
          state_next = prereg_pkg::ST_RESET;
          pre_en_next = 1'b1;
          to_cnt_next = '0;
        end
      end
      prereg_pkg::ST_OFF: begin
        if (wake) begin
          // Hand the kept fault to software on power-up
          rpt_set = latch_reg;
          latch_next = 2'h0;
          state_next = prereg_pkg::ST_RESET;
          pre_en_next = 1'b1;
          dis_next = 1'b0;
          to_cnt_next = '0;
        end
      end
      default: begin
        state_next = prereg_pkg::ST_OFF;
      end
    endcase
    if (fault) begin
      // Every fault exit switches all regulators off
      pre_en_next = 1'b0;
      lv_en_next = 1'b0;
      bst_en_next = 1'b0;
      hs_off_next = 1'b0;
      ls_on_next = 1'b0;
      if (fault_off) begin
        state_next = prereg_pkg::ST_OFF;
        dis_next = 1'b1;
        latch_next = latch_reg | fault_lat;
      end else begin
        err_cnt_next = cnt_inc;
        pin_set = 1'b1;
        dis_next = 1'b0;
        state_next = (cnt_inc >= thr) ? prereg_pkg::ST_OFF : prereg_pkg::ST_SAFE;
      end
    end
    // Registered copy of the OFF state keeps the output off a decoder
    off_next = (state_next == prereg_pkg::ST_OFF);
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= prereg_pkg::ST_ACTIVE;
      pre_en_reg <= 1'b1;
      hs_off_reg <= 1'b0;
      ls_on_reg <= 1'b0;
      lv_en_reg <= 1'b1;
      bst_en_reg <= 1'b1;
      dis_reg <= 1'b0;
      latch_reg <= 2'h0;
      err_cnt_reg <= 4'h0;
      to_cnt_reg <= '0;
      off_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pre_en_reg <= pre_en_next;
      hs_off_reg <= hs_off_next;
      ls_on_reg <= ls_on_next;
      lv_en_reg <= lv_en_next;
      bst_en_reg <= bst_en_next;
      dis_reg <= dis_next;
      latch_reg <= latch_next;
      err_cnt_reg <= err_cnt_next;
      to_cnt_reg <= to_cnt_next;
      off_reg <= off_next;
    end
  end

  // APB decode and software registers
  always_comb begin
    logic acc; // Access phase, not yet answered
    logic done; // Completing edge
    logic [2:0] clr; // Write-one-to-clear bits
    acc = psel & penable & ~rdy_reg;
    done = psel & penable & rdy_reg;
    clr = 3'h0;
    mask_next = mask_reg;
    ctrl_next = ctrl_reg;
    rdata_next = rdata_reg;
    rdy_next = acc;
    err_next = 1'b0;
    if (done && pwrite && paddr == `A_STATUS) begin
      clr = pwdata[2:0];
    end else if (done && pwrite && paddr == `A_MASK) begin
      mask_next = pwdata[2:0];
    end else if (done && pwrite && paddr == `A_CTRL) begin
      ctrl_next = {20'h0_0000, pwdata[`C_THR_HI:`C_THR_LO], 3'h0, pwdata[4:0]};
    end
    if (acc) begin
      rdata_next = 32'h0000_0000;
      if (paddr == `A_STATUS) begin
        rdata_next[2:0] = status_reg;
      end else if (paddr == `A_MASK) begin
        rdata_next[2:0] = mask_reg;
      end else if (paddr == `A_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (paddr == `A_STATE) begin
        rdata_next = {14'h0000, latch_reg, 4'h0, err_cnt_reg, 3'h0, state_reg};
      end else begin
        err_next = 1'b1;
      end
    end
    // A new event wins over a clear in the same cycle
    status_next = (status_reg & ~clr) | stat_set | {rpt_set, 1'b0};
    pin_n_next = ~(pin_set | (~pin_n_reg & ~(|clr[2:1])));
    irq_next = |(status_reg & mask_reg);
  end

  // Software register bank
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_reg <= 3'h0;
      mask_reg <= `MASK_RST;
      ctrl_reg <= `CTRL_RST;
      pin_n_reg <= 1'b1;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      ctrl_reg <= ctrl_next;
      pin_n_reg <= pin_n_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
      rdy_reg <= rdy_next;
      err_reg <= err_next;
    end
  end

  // Outputs straight from flops
  assign prdata = rdata_reg;
  assign pready = rdy_reg;
  assign pslverr = err_reg;
  assign wide_input_preregulator_en = pre_en_reg;
  assign hs_force_off = hs_off_reg;
  assign ls_force_on = ls_on_reg;
  assign low_voltage_step_down_en = lv_en_reg;
  assign boost_en = bst_en_reg;
  assign discharge_en = dis_reg;
  assign interrupt_enable_drive_pin_n = pin_n_reg;
  assign irq = irq_reg;
  assign power_off = off_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_sc_release;
    state_reg == prereg_pkg::ST_SC_HOLD && !ovc_now;
  endsequence

  property p_ovc_flag;
    ovc_now && state_reg == prereg_pkg::ST_ACTIVE && !scg_now && !sink_exp
      |=> status_reg[`B_OVC] && pre_en_reg;
  endproperty
  a_ovc_flag: assert property (p_ovc_flag) else $error("overload mishandled");

  property p_sc_hold;
    state_reg == prereg_pkg::ST_SC_HOLD |-> hs_off_reg && ls_on_reg;
  endproperty
  a_sc_hold: assert property (p_sc_hold) else $error("short hold drive wrong");

  property p_sc_done;
    s_sc_release |=> status_reg[`B_SCG] && !pre_en_reg && !hs_off_reg;
  endproperty
  a_sc_done: assert property (p_sc_done) else $error("short exit wrong");

  property p_sc_off;
    s_sc_release ##0 ctrl_reg[`C_SCOFF] |=> power_off && dis_reg && latch_reg[0];
  endproperty
  a_sc_off: assert property (p_sc_off) else $error("short OFF path wrong");

  property p_safe_out;
    state_reg == prereg_pkg::ST_SAFE |-> !pre_en_reg && !lv_en_reg && !bst_en_reg && !dis_reg;
  endproperty
  a_safe_out: assert property (p_safe_out) else $error("SAFE outputs wrong");

  property p_safe_entry;
    $rose(state_reg == prereg_pkg::ST_SAFE)
      |-> !interrupt_enable_drive_pin_n && err_cnt_reg == $past(err_cnt_reg) + 4'h1;
  endproperty
  a_safe_entry: assert property (p_safe_entry) else $error("SAFE entry wrong");

  property p_boost_order;
    $rose(bst_en_reg) && state_reg != prereg_pkg::ST_ACTIVE |-> $past(lv_en_reg);
  endproperty
  a_boost_order: assert property (p_boost_order) else $error("boost early");

  property p_sink_stop;
    sink_exp && state_reg == prereg_pkg::ST_ACTIVE && !scg_now
      |=> !pre_en_reg && state_reg != prereg_pkg::ST_ACTIVE;
  endproperty
  a_sink_stop: assert property (p_sink_stop) else $error("sink not stopped");

  property p_sink_blank;
    pre_en_reg && !uv_ok && !status_reg[`B_SINK] && state_reg != prereg_pkg::ST_OFF
      |=> !status_reg[`B_SINK];
  endproperty
  a_sink_blank: assert property (p_sink_blank) else $error("sink not blanked");

endmodule : prereg_overcurrent_fault_response

// ===== design/prereg_pkg.sv
package prereg_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_ACTIVE = 5'h01,
    ST_SC_HOLD = 5'h02,
    ST_SAFE = 5'h04,
    ST_RESET = 5'h08,
    ST_OFF = 5'h10
  } seq_state_e;

endpackage : prereg_pkg

// ===== design/sink_timer.sv
`timescale 1ns/1ps
`include "prereg_defs.svh"

module sink_timer #(
  parameter int CNT_W = 12,
  parameter int LIMIT = `SINK_CYC
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic active, // Qualified sink event present
  output logic expired // Event lasted LIMIT cycles
);

  // Refuse a limit the counter cannot reach
  if (LIMIT < 2 || LIMIT >= (1 << CNT_W)) begin : g_chk
    $error("sink_timer: LIMIT does not fit CNT_W");
  end

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1); // Final count

  logic [CNT_W-1:0] count_reg; // Cycles the event has lasted
  logic [CNT_W-1:0] count_next;
  logic expired_reg; // Registered expiry level
  logic expired_next;

  // Count while the event holds, restart when it drops
  always_comb begin
    count_next = '0;
    expired_next = 1'b0;
    if (active) begin
      count_next = (count_reg == LAST) ? count_reg : count_reg + 1'b1;
      expired_next = (count_reg == LAST);
    end
  end

  // Register the counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;

endmodule : sink_timer

// ===== verif/reg_plant_model.sv
`timescale 1ns/1ps

// Regulator outputs as the comparators see them
module reg_plant_model #(
  parameter int UP_DLY = 8, // Cycles until preregulator passes UV
  parameter int DN_DLY = 40 // Cycles until outputs fall below UV
) (
  input wire logic clk, // System clock
  input wire logic pre_en, // Preregulator enable
  input wire logic lv_en, // Low-voltage buck enable
  input wire logic bst_en, // Boost enable
  input wire logic uv_block, // Holds preregulator under UV
  output logic uv_ok, // Preregulator above UV
  output logic below_uv // All outputs below UV
);
  int up_cnt = 0; // Soft-start progress
  int dn_cnt = 0; // Discharge progress
  // Voltages follow the enables slowly, as a real output capacitor does
  always_ff @(posedge clk) begin
    up_cnt <= !pre_en ? 0 : (up_cnt < UP_DLY ? up_cnt + 1 : up_cnt);
    dn_cnt <= (pre_en | lv_en | bst_en) ? 0 : (dn_cnt < DN_DLY ? dn_cnt + 1 : dn_cnt);
  end
  assign uv_ok = (up_cnt == UP_DLY) && !uv_block;
  assign below_uv = (dn_cnt == DN_DLY);
endmodule : reg_plant_model

// ===== verif/tb_prereg_overcurrent_fault_response.sv
`timescale 1ns/1ps
`include "prereg_defs.svh"

module tb_prereg_overcurrent_fault_response;
  logic clk = 1'b0; // System clock
  logic sys_rst = 1'b1; // Synchronous reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0000_0000; // APB write data
  logic [31:0] prdata, q; // Read data, last read
  logic pready, pslverr, e; // APB answer, last error
  logic hs_ovc = 1'b0, ls_ovc = 1'b0, hs_scg = 1'b0, ls_scg = 1'b0; // Comparators
  logic scg_sel = 1'b0; // Short comparator used next, alternates
  logic sink = 1'b0, crit = 1'b0, wake = 1'b0, uv_block = 1'b0; // Analog side
  logic uv_ok, below_uv; // Plant outputs
  logic pre_en, hs_off, ls_on, lv_en, bst_en, dis_en, pin_n, irq, pwr_off; // Outputs
  int error_cnt = 0; // Mismatches
  int n_checks = 0; // Comparisons

  // Clock at 200 MHz
  initial forever #2.5 clk = ~clk;

  prereg_overcurrent_fault_response #(.RESET_TIMEOUT_CYC(50)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hs_ovc_pin(hs_ovc), .ls_ovc_pin(ls_ovc), .hs_scg_pin(hs_scg), .ls_scg_pin(ls_scg),
    .ls_sink_pin(sink), .prereg_uv_ok_pin(uv_ok), .outputs_below_uv_pin(below_uv),
    .prereg_crit_pin(crit), .wake_pin(wake), .wide_input_preregulator_en(pre_en),
    .hs_force_off(hs_off), .ls_force_on(ls_on), .low_voltage_step_down_en(lv_en),
    .boost_en(bst_en), .discharge_en(dis_en), .interrupt_enable_drive_pin_n(pin_n),
    .irq(irq), .power_off(pwr_off));

  reg_plant_model plant_u (
    .clk(clk), .pre_en(pre_en), .lv_en(lv_en), .bst_en(bst_en),
    .uv_block(uv_block), .uv_ok(uv_ok), .below_uv(below_uv));

  // Compare and count
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask : check

  // Verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // One APB transfer, waiting for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) check("pready", 32'h0, 32'h1);
  endtask : apb

  // Write one register
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Read and compare masked bits
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                     input string nm);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, q & m, x);
  endtask : rdc

  // Poll the state register until it shows s
  task automatic wst(input logic [4:0] s, input int lim);
    int n = 0;
    do begin
      apb(1'b0, `A_STATE, 32'h0000_0000);
      n++;
    end while (q[4:0] !== s && n < lim);
    check("state", {27'h0, q[4:0]}, {27'h0, s});
  endtask : wst

  // Compare regulator enables, discharge and pin
  task automatic outs(input logic [4:0] x, input string nm);
    check(nm, {27'h0, pre_en, lv_en, bst_en, dis_en, pin_n}, {27'h0, x});
  endtask : outs

  // Reset held for 12 cycles
  task automatic rst_dut;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : rst_dut

  // Short with overload, released after the hold
  task automatic short_evt;
    @(posedge clk);
    hs_scg <= ~scg_sel;
    ls_scg <= scg_sel;
    ls_ovc <= 1'b1;
    repeat (6) @(posedge clk);
    check("sc_hold", {30'h0, hs_off, ls_on}, 32'h3);
    hs_scg <= 1'b0;
    ls_scg <= 1'b0;
    ls_ovc <= 1'b0;
    scg_sel = ~scg_sel;
  endtask : short_evt

  // Sink current held until the state leaves ACTIVE
  task automatic sink_evt(input logic [4:0] s);
    wr(`A_STATUS, 32'h0000_0007);
    @(posedge clk);
    sink <= 1'b1;
    repeat (3950) @(posedge clk);
    rdc(`A_STATUS, 32'h4, 32'h4, "sink_flag");
    rdc(`A_STATE, 32'h1F, 32'h1, "sink_run");
    wst(s, 40);
    sink <= 1'b0;
  endtask : sink_evt

  // Wake request from OFF
  task automatic wake_up;
    wr(`A_STATUS, 32'h0000_0007);
    @(posedge clk);
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    wst(prereg_pkg::ST_ACTIVE, 100);
  endtask : wake_up

  // Boost never on without the low-voltage buck
  always @(posedge clk) begin
    if (!sys_rst && bst_en === 1'b1 && lv_en !== 1'b1) check("order", 32'h1, 32'h0);
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    check("watchdog", 32'h1, 32'h0);
    results;
  end

  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(`A_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, "status_rst");
    rdc(`A_MASK, 32'hFFFF_FFFF, {29'h0, `MASK_RST}, "mask_rst");
    rdc(`A_CTRL, 32'hFFFF_FFFF, `CTRL_RST, "ctrl_rst");
    rdc(`A_STATE, 32'hFFFF_FFFF, 32'h0000_0001, "state_rst");
    outs(5'b11101, "outs_rst");
    check("irq_rst", {30'h0, irq, pwr_off}, 32'h0);
    wr(`A_MASK, 32'hFFFF_FFFF);
    rdc(`A_MASK, 32'hFFFF_FFFF, 32'h0000_0007, "mask_width");
    wr(`A_STATE, 32'hFFFF_FFFF);
    rdc(`A_STATE, 32'hFFFF_FFFF, 32'h0000_0001, "state_ro");
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped", {q[30:0], e}, 32'h1);
    $display("test reset_and_map done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      hs_ovc <= (i == 0);
      ls_ovc <= (i == 1);
      repeat (6) @(posedge clk);
      hs_ovc <= 1'b0;
      ls_ovc <= 1'b0;
      rdc(`A_STATUS, 32'hFFFF_FFFF, 32'h1, "ovl_flag");
      rdc(`A_STATE, 32'h1F, 32'h1, "ovl_run");
      outs(5'b11101, "ovl_outs");
      check("irq_set", {31'h0, irq}, 32'h1);
      wr(`A_MASK, 32'h0000_0006);
      repeat (2) @(posedge clk);
      check("irq_mask", {31'h0, irq}, 32'h0);
      wr(`A_MASK, 32'h0000_0007);
      wr(`A_STATUS, 32'h0000_0001);
      rdc(`A_STATUS, 32'hFFFF_FFFF, 32'h0, "ovl_clear");
      check("irq_clr", {31'h0, irq}, 32'h0);
    end
    $display("test overload done");
    short_evt;
    wst(prereg_pkg::ST_SAFE, 20);
    outs(5'b00000, "safe_outs");
    rdc(`A_STATUS, 32'h2, 32'h2, "sc_flag");
    rdc(`A_STATE, 32'hF00, 32'h100, "sc_count");
    wst(prereg_pkg::ST_ACTIVE, 60);
    outs(5'b11100, "recover");
    wr(`A_STATUS, 32'h0000_0007);
    repeat (2) @(posedge clk);
    check("pin_rel", {30'h0, pin_n, irq}, 32'h2);
    wr(`A_CTRL, 32'h0000_0F05);
    short_evt;
    wst(prereg_pkg::ST_OFF, 20);
    outs(5'b00011, "off_outs");
    check("pwr_off", {31'h0, pwr_off}, 32'h1);
    rdc(`A_STATE, 32'h3_0000, 32'h1_0000, "sc_latch");
    wake_up;
    rdc(`A_STATUS, 32'h2, 32'h2, "sc_report");
    $display("test short done");
    wr(`A_CTRL, 32'h0000_0F04);
    wr(`A_STATUS, 32'h0000_0007);
    @(posedge clk);
    uv_block <= 1'b1;
    sink <= 1'b1;
    repeat (4100) @(posedge clk);
    sink <= 1'b0;
    uv_block <= 1'b0;
    rdc(`A_STATUS, 32'hFFFF_FFFF, 32'h0, "sink_mask");
    rdc(`A_STATE, 32'h1F, 32'h1, "sink_ign");
    repeat (10) @(posedge clk);
    sink_evt(prereg_pkg::ST_SAFE);
    outs(5'b00000, "sink_safe");
    rdc(`A_STATE, 32'hF00, 32'h200, "sink_count");
    wst(prereg_pkg::ST_ACTIVE, 60);
    wr(`A_CTRL, 32'h0000_0F06);
    sink_evt(prereg_pkg::ST_OFF);
    rdc(`A_STATE, 32'h3_0000, 32'h2_0000, "sink_latch");
    wake_up;
    rdc(`A_STATUS, 32'h4, 32'h4, "sink_report");
    $display("test sink done");
    rst_dut;
    wr(`A_CTRL, 32'h0000_0204);
    short_evt;
    wst(prereg_pkg::ST_SAFE, 20);
    wst(prereg_pkg::ST_ACTIVE, 60);
    short_evt;
    wst(prereg_pkg::ST_OFF, 20);
    check("thr_outs", {28'h0, pre_en, lv_en, bst_en, dis_en}, 32'h0);
    $display("test threshold done");
    rst_dut;
    wr(`A_CTRL, 32'h0000_0F00);
    short_evt;
    wst(prereg_pkg::ST_SAFE, 20);
    repeat (100) @(posedge clk);
    rdc(`A_STATE, 32'h1F, 32'h4, "no_uv_rst");
    crit <= 1'b1;
    wr(`A_CTRL, 32'h0000_0F04);
    wst(prereg_pkg::ST_RESET, 20);
    check("crit_hold", {31'h0, pre_en}, 32'h0);
    wst(prereg_pkg::ST_OFF, 40);
    crit <= 1'b0;
    $display("test reset_timeout done");
    results;
  end
endmodule : tb_prereg_overcurrent_fault_response
